/* pkg/dct_pkg.sv */
package dct_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DCT_DATA_W = 16;
    localparam int DCT_ADDR_W = 24;
    localparam int DCT_LINE_W = 64;
    localparam int DCT_NCMP   = 4;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] DCT_OFS_CTRL  = 16'h0020;
    localparam logic [15:0] DCT_OFS_BRKEN = 16'h0021;
    localparam logic [15:0] DCT_OFS_TBH   = 16'h0024;
    localparam logic [15:0] DCT_OFS_TBL   = 16'h0025;
    localparam logic [15:0] DCT_OFS_CNT   = 16'h0026;
    localparam logic [15:0] DCT_OFS_WIN   = 16'h0028;

    // ------------------------------------------------------------------
    // Byte positions inside the shared comparator window
    // ------------------------------------------------------------------
    localparam logic [2:0] DCT_WB_CTL = 3'h0;
    localparam logic [2:0] DCT_WB_AH  = 3'h1;
    localparam logic [2:0] DCT_WB_AM  = 3'h2;
    localparam logic [2:0] DCT_WB_AL  = 3'h3;
    localparam logic [2:0] DCT_WB_DH  = 3'h4;
    localparam logic [2:0] DCT_WB_DL  = 3'h5;
    localparam logic [2:0] DCT_WB_MH  = 3'h6;
    localparam logic [2:0] DCT_WB_ML  = 3'h7;

    // ------------------------------------------------------------------
    // comparator_control fields
    // ------------------------------------------------------------------
    localparam int DCT_CB_SIZE_EN  = 7;
    localparam int DCT_CB_INV_DATA = 6;
    localparam int DCT_CB_SIZE_VAL = 6;
    localparam int DCT_CB_TAG      = 5;
    localparam int DCT_CB_STOP     = 4;
    localparam int DCT_CB_DIR_VAL  = 3;
    localparam int DCT_CB_DIR_EN   = 2;

    // ------------------------------------------------------------------
    // Module control register fields
    // ------------------------------------------------------------------
    localparam int DCT_CR_ARM   = 7;
    localparam int DCT_CR_TRACE = 6;
    localparam int DCT_CR_VIEW  = 0;

    // ------------------------------------------------------------------
    // Trace line layout and reset values
    // ------------------------------------------------------------------
    localparam int DCT_TE_DIR      = 5;
    localparam int DCT_TE_DATA_LSB = 16;
    localparam int DCT_TE_ADDR_LSB = 32;

    localparam logic [7:0]            DCT_CTL_RST     = 8'h00;
    localparam logic [DCT_DATA_W-1:0] DCT_INVALID_WRD = 16'hFFFF;

    typedef enum logic [1:0] {
        DCT_VIEW_A,
        DCT_VIEW_B,
        DCT_VIEW_C,
        DCT_VIEW_D
    } dct_view_type;

endpackage : dct_pkg

/* pkg/dct_cmp_if.sv */
`timescale 1ns/100ps
interface dct_cmp_if import dct_pkg::*; ();
    logic [7:0]            ctl;
    logic [DCT_ADDR_W-1:0] addr;
    logic [DCT_DATA_W-1:0] data;
    logic [DCT_DATA_W-1:0] mask;
    logic                  armed;
    logic                  trig;

    modport cfg (output ctl, output addr, output data, output mask, output armed, input trig);
    modport cmp (input ctl, input addr, input data, input mask, input armed, output trig);
endinterface : dct_cmp_if

/* hdl/dct_comparator.sv */
`timescale 1ns/100ps
module dct_comparator import dct_pkg::*; #(
    parameter bit HAS_DATA = 1'b1
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    dct_cmp_if.cmp                     cfg,
    input  wire logic                  mon_valid,
    input  wire logic [DCT_ADDR_W-1:0] mon_addr,
    input  wire logic [DCT_DATA_W-1:0] mon_data,
    input  wire logic                  mon_read,
    input  wire logic                  mon_byte,
    input  wire logic                  exec_valid,
    input  wire logic [DCT_ADDR_W-1:0] exec_addr
);

    // ------------------------------------------------------------------
    // Qualifiers
    // ------------------------------------------------------------------
    logic tag_pend_r;
    logic tag_pend_nxt;

    wire tag_mode = cfg.ctl[DCT_CB_TAG];
    wire addr_hit = mon_valid && (mon_addr == cfg.addr);
    wire data_eq  = (((mon_data ^ cfg.data) & cfg.mask) == '0);
    wire data_ok  = !HAS_DATA || (data_eq ^ cfg.ctl[DCT_CB_INV_DATA]);
    wire size_ok  = HAS_DATA || !cfg.ctl[DCT_CB_SIZE_EN]
                    || (mon_byte == cfg.ctl[DCT_CB_SIZE_VAL]);
    wire dir_ok   = !cfg.ctl[DCT_CB_DIR_EN]
                    || (mon_read == cfg.ctl[DCT_CB_DIR_VAL]);
    wire full_hit = addr_hit && data_ok && size_ok && dir_ok;
    wire exec_hit = exec_valid && (exec_addr == cfg.addr);

    // Tagged opcodes only fire once the tagged address reaches execution.
    assign tag_pend_nxt = !cfg.armed || !tag_mode ? 1'b0 :
                          addr_hit ? 1'b1 :
                          exec_hit ? 1'b0 : tag_pend_r;
    assign cfg.trig = tag_mode ? (tag_pend_r && exec_hit) : full_hit;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tag_pend_r <= 1'b0;
        end else begin
            tag_pend_r <= tag_pend_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    dir_qual_a: assert property (!tag_mode && cfg.ctl[DCT_CB_DIR_EN]
        && (mon_read != cfg.ctl[DCT_CB_DIR_VAL]) |-> !cfg.trig)
        else $error("direction qualifier ignored");
    data_qual_a: assert property (HAS_DATA && !tag_mode && addr_hit
        && (data_eq == cfg.ctl[DCT_CB_INV_DATA]) |-> !cfg.trig)
        else $error("data qualifier ignored");
    size_qual_a: assert property (!HAS_DATA && !tag_mode
        && cfg.ctl[DCT_CB_SIZE_EN] && (mon_byte != cfg.ctl[DCT_CB_SIZE_VAL])
        |-> !cfg.trig)
        else $error("size qualifier ignored");
    tag_exec_a: assert property (cfg.armed && tag_mode && addr_hit && !exec_hit
        ##1 cfg.armed && tag_mode && exec_hit |-> cfg.trig)
        else $error("tagged opcode did not trigger at execution");

endmodule : dct_comparator

/* hdl/dct_top.sv */
`timescale 1ns/100ps
module dct_top import dct_pkg::*; #(
    parameter int TRACE_DEPTH = 64
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  bus_req,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_word,
    input  wire logic [15:0]           bus_addr,
    input  wire logic [DCT_DATA_W-1:0] bus_wdata,
    output logic      [DCT_DATA_W-1:0] bus_rdata,
    output logic                       bus_ack,
    input  wire logic                  mon_valid,
    input  wire logic [DCT_ADDR_W-1:0] mon_addr,
    input  wire logic [DCT_DATA_W-1:0] mon_data,
    input  wire logic                  mon_read,
    input  wire logic                  mon_byte,
    input  wire logic                  exec_valid,
    input  wire logic [DCT_ADDR_W-1:0] exec_addr,
    input  wire logic                  secured,
    output logic                       armed,
    output logic                       breakpoint_req
);

    localparam int PTR_W = $clog2(TRACE_DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [PTR_W-1:0] LAST_LINE = PTR_W'(TRACE_DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT  = CNT_W'(TRACE_DEPTH);

    generate
        if (TRACE_DEPTH < 2 || TRACE_DEPTH > 128 || (TRACE_DEPTH & (TRACE_DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("TRACE_DEPTH must be a power of two from 2 to 128");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]            ctl_r  [DCT_NCMP];
    logic [DCT_ADDR_W-1:0] addr_r [DCT_NCMP];
    logic [DCT_DATA_W-1:0] data_r [DCT_NCMP];
    logic [DCT_DATA_W-1:0] mask_r [DCT_NCMP];
    logic                  arm_r;
    logic                  trace_en_r;
    logic [1:0]            view_r;
    logic                  brk_en_r;
    logic                  unlocked_r;
    logic [PTR_W-1:0]      rd_line_r;
    logic [1:0]            rd_word_r;
    logic [DCT_DATA_W-1:0] rdata_nxt;
    logic                  brk_req_r;
    // Trace store, write pointer, overflow and count are never reset so
    // that a session cut short by a system reset stays readable.
    logic [DCT_LINE_W-1:0] tb_mem [TRACE_DEPTH];
    logic [PTR_W-1:0]      wr_ptr_r;
    logic                  ovf_r;
    logic [CNT_W-1:0]      count_r;
    logic [DCT_NCMP-1:0]   trig_vec;
    logic [DCT_NCMP-1:0]   stop_vec;
    logic [1:0]            first_idx;

    dct_cmp_if cmp_bus [DCT_NCMP] ();

    // ------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------
    for (genvar g = 0; g < DCT_NCMP; g++) begin : g_cmp
        assign cmp_bus[g].ctl   = ctl_r[g];
        assign cmp_bus[g].addr  = addr_r[g];
        assign cmp_bus[g].data  = data_r[g];
        assign cmp_bus[g].mask  = mask_r[g];
        assign cmp_bus[g].armed = arm_r;
        assign trig_vec[g]      = cmp_bus[g].trig && arm_r;
        assign stop_vec[g]      = trig_vec[g] && ctl_r[g][DCT_CB_STOP];
        dct_comparator #(
            .HAS_DATA ((g % 2) == 0)
        ) u_cmp (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .cfg        (cmp_bus[g]),
            .mon_valid  (mon_valid),
            .mon_addr   (mon_addr),
            .mon_data   (mon_data),
            .mon_read   (mon_read),
            .mon_byte   (mon_byte),
            .exec_valid (exec_valid),
            .exec_addr  (exec_addr)
        );
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire        bus_rd     = bus_req && !bus_wr;
    wire        tb_hit     = bus_word && (bus_addr == DCT_OFS_TBH);
    wire        tb_rd      = bus_rd && tb_hit;
    wire        tb_wr      = bus_req && bus_wr && tb_hit;
    wire        readable   = !arm_r && trace_en_r && !secured && unlocked_r;
    wire        tb_advance = tb_rd && readable;
    wire        stop_any   = |stop_vec;
    wire        capture    = arm_r && trace_en_r && (|trig_vec);
    wire        arm_wr     = bus_req && bus_wr && (bus_addr == DCT_OFS_CTRL);
    wire        arm_val    = bus_word ? bus_wdata[8 + DCT_CR_ARM] : bus_wdata[DCT_CR_ARM];
    wire        start      = arm_wr && arm_val && !arm_r;
    wire [PTR_W-1:0] oldest   = ovf_r ? wr_ptr_r : '0;
    wire [DCT_LINE_W-1:0] cur_line = tb_mem[rd_line_r];
    wire [DCT_DATA_W-1:0] cur_word = cur_line[rd_word_r * DCT_DATA_W +: DCT_DATA_W];
    wire [15:0] lane_addr [2];
    wire [7:0]  lane_val  [2];
    wire        lane_we   [2];

    assign lane_addr[0] = bus_addr;
    assign lane_addr[1] = bus_addr + 16'h0001;
    assign lane_val[0]  = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];
    assign lane_val[1]  = bus_wdata[7:0];
    assign lane_we[0]   = bus_req && bus_wr;
    assign lane_we[1]   = bus_req && bus_wr && bus_word;
    assign first_idx    = trig_vec[0] ? 2'h0 : trig_vec[1] ? 2'h1 : trig_vec[2] ? 2'h2 : 2'h3;

    function automatic logic in_win(input logic [15:0] a);
        in_win = (a[15:3] == DCT_OFS_WIN[15:3]);
    endfunction : in_win

    // One register byte as software sees it; trace port bytes read zero.
    function automatic logic [7:0] rd_byte(input logic [15:0] a);
        dct_view_type v;
        logic         wide;
        v    = dct_view_type'(view_r);
        wide = (v == DCT_VIEW_A) || (v == DCT_VIEW_C);
        rd_byte = 8'h00;
        if (a == DCT_OFS_CTRL) begin
            rd_byte = {arm_r, trace_en_r, 4'h0, view_r};
        end else if (a == DCT_OFS_BRKEN) begin
            rd_byte = {7'h00, brk_en_r};
        end else if (a == DCT_OFS_CNT) begin
            rd_byte = 8'(count_r);
        end else if (in_win(a)) begin
            unique case (a[2:0])
                DCT_WB_CTL: rd_byte = ctl_r[v];
                DCT_WB_AH:  rd_byte = addr_r[v][23:16];
                DCT_WB_AM:  rd_byte = addr_r[v][15:8];
                DCT_WB_AL:  rd_byte = addr_r[v][7:0];
                DCT_WB_DH:  rd_byte = wide ? data_r[v][15:8] : 8'h00;
                DCT_WB_DL:  rd_byte = wide ? data_r[v][7:0] : 8'h00;
                DCT_WB_MH:  rd_byte = wide ? mask_r[v][15:8] : 8'h00;
                DCT_WB_ML:  rd_byte = wide ? mask_r[v][7:0] : 8'h00;
            endcase
        end
    endfunction : rd_byte

    always_comb begin
        rdata_nxt = '0;
        if (tb_rd) begin
            rdata_nxt = arm_r ? DCT_INVALID_WRD : readable ? cur_word : '0;
        end else if (bus_rd && bus_word) begin
            rdata_nxt = {rd_byte(lane_addr[0]), rd_byte(lane_addr[1])};
        end else if (bus_rd) begin
            rdata_nxt = {8'h00, rd_byte(bus_addr)};
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DCT_NCMP; i++) begin
                ctl_r[i]  <= DCT_CTL_RST;
                addr_r[i] <= '0;
                data_r[i] <= '0;
                mask_r[i] <= '0;
            end
            trace_en_r <= 1'b0;
            view_r     <= '0;
            brk_en_r   <= 1'b0;
        end else begin
            for (int l = 0; l < 2; l++) begin
                if (lane_we[l] && lane_addr[l] == DCT_OFS_CTRL) begin
                    trace_en_r <= lane_val[l][DCT_CR_TRACE];
                    view_r     <= lane_val[l][DCT_CR_VIEW +: 2];
                end
                if (lane_we[l] && lane_addr[l] == DCT_OFS_BRKEN) begin
                    brk_en_r <= lane_val[l][0];
                end
                if (lane_we[l] && in_win(lane_addr[l])) begin
                    unique case (lane_addr[l][2:0])
                        DCT_WB_CTL: ctl_r[view_r]         <= lane_val[l];
                        DCT_WB_AH:  addr_r[view_r][23:16] <= lane_val[l];
                        DCT_WB_AM:  addr_r[view_r][15:8]  <= lane_val[l];
                        DCT_WB_AL:  addr_r[view_r][7:0]   <= lane_val[l];
                        DCT_WB_DH:  if (!view_r[0]) data_r[view_r][15:8] <= lane_val[l];
                        DCT_WB_DL:  if (!view_r[0]) data_r[view_r][7:0]  <= lane_val[l];
                        DCT_WB_MH:  if (!view_r[0]) mask_r[view_r][15:8] <= lane_val[l];
                        DCT_WB_ML:  if (!view_r[0]) mask_r[view_r][7:0]  <= lane_val[l];
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Session control and readout pointer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arm_r      <= 1'b0;
            unlocked_r <= 1'b0;
            rd_line_r  <= '0;
            rd_word_r  <= '0;
            brk_req_r  <= 1'b0;
            bus_rdata  <= '0;
            bus_ack    <= 1'b0;
        end else begin
            bus_rdata <= rdata_nxt;
            bus_ack   <= bus_req;
            brk_req_r <= stop_any && brk_en_r;
            if (arm_wr) begin
                arm_r <= arm_val;
            end
            if (arm_wr && arm_val) begin
                unlocked_r <= 1'b0;
            end
            if (stop_any) begin
                arm_r <= 1'b0;
            end
            if (tb_wr) begin
                rd_line_r <= oldest;
                rd_word_r <= '0;
                if (!arm_r) begin
                    unlocked_r <= 1'b1;
                end
            end else if (tb_advance) begin
                rd_word_r <= rd_word_r + 2'h1;
                if (rd_word_r == 2'h3) begin
                    rd_line_r <= rd_line_r + PTR_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Trace capture
    // ------------------------------------------------------------------
    // The store ignores sys_rst on purpose; the count only moves at session
    // start and on capture, never on readout.
    always_ff @(posedge clk) begin
        if (start) begin
            wr_ptr_r <= '0;
            ovf_r    <= 1'b0;
            count_r  <= '0;
        end else if (capture) begin
            tb_mem[wr_ptr_r] <= {8'h00, DCT_ADDR_W'(mon_addr), mon_data, 8'h00,
                                 2'h0, mon_read, 3'h0, first_idx};
            wr_ptr_r         <= wr_ptr_r + PTR_W'(1);
            ovf_r            <= ovf_r || (wr_ptr_r == LAST_LINE);
            count_r          <= (count_r == FULL_CNT) ? count_r : count_r + CNT_W'(1);
        end
    end

    assign armed          = arm_r;
    assign breakpoint_req = brk_req_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    stop_disarm_a: assert property (stop_any |=> !armed)
        else $error("stop match left the module armed");
    brk_pulse_a: assert property (stop_any && brk_en_r |=> breakpoint_req ##1 !breakpoint_req
        or stop_any)
        else $error("breakpoint request not a pulse after stop");
    armed_read_a: assert property (tb_rd && arm_r && !tb_wr
        |=> bus_rdata == DCT_INVALID_WRD && $stable(rd_line_r) && $stable(rd_word_r))
        else $error("armed readout not invalid or pointer moved");
    byte_read_a: assert property (bus_rd && !bus_word && (bus_addr == DCT_OFS_TBH
        || bus_addr == DCT_OFS_TBL) |=> bus_rdata == '0 && $stable(rd_word_r))
        else $error("byte readout returned data or moved pointer");
    unlock_ptr_a: assert property (tb_wr && !arm_r
        |=> unlocked_r && rd_line_r == $past(oldest) && rd_word_r == 2'h0)
        else $error("unlock did not rewind to oldest entry");
    lock_on_arm_a: assert property (arm_wr && arm_val |=> !unlocked_r)
        else $error("arming did not lock the trace store");
    count_hold_a: assert property (tb_rd && !arm_r && !start |=> $stable(count_r))
        else $error("line count changed on readout");
    word_order_a: assert property (tb_advance && rd_word_r == 2'h3 && !tb_wr
        |=> rd_word_r == 2'h0 && rd_line_r == $past(rd_line_r) + PTR_W'(1))
        else $error("line readout order wrong");
    gated_read_a: assert property (tb_rd && !arm_r && (secured || !trace_en_r)
        |=> bus_rdata == '0)
        else $error("readout delivered data while gated");
    view_d_a: assert property (bus_rd && !bus_word && view_r == 2'h3
        && bus_addr == DCT_OFS_WIN |=> bus_rdata[7:0] == $past(ctl_r[3]))
        else $error("view select 11 did not show comparator D");

    stop_seen_c:    cover property (arm_r && stop_any ##1 breakpoint_req);
    full_line_c:    cover property (tb_advance && rd_word_r == 2'h3);
    unlock_read_c:  cover property (tb_wr && !arm_r ##1 tb_advance);
    overflow_c:     cover property (capture && wr_ptr_r == LAST_LINE);

endmodule : dct_top

/* verif/dct_core_model.sv */
`timescale 1ns/100ps
module dct_core_model import dct_pkg::*; (
    input  wire logic                  clk,
    input  wire logic                  go,
    input  wire logic [DCT_ADDR_W-1:0] g_addr,
    input  wire logic [DCT_DATA_W-1:0] g_data,
    input  wire logic                  g_read,
    output logic                       mon_valid,
    output logic      [DCT_ADDR_W-1:0] mon_addr,
    output logic      [DCT_DATA_W-1:0] mon_data,
    output logic                       mon_read,
    output logic                       mon_byte,
    output logic                       exec_valid,
    output logic      [DCT_ADDR_W-1:0] exec_addr
);
    initial {mon_valid, mon_addr, mon_data, mon_read, mon_byte, exec_valid, exec_addr} = '0;
    // Idle lines toggle every cycle, so a stale value can never pass for a live bus cycle.
    always @(posedge clk) begin
        mon_valid  <= go;
        mon_addr   <= go ? g_addr : ~mon_addr;
        mon_data   <= go ? g_data : ~mon_data;
        mon_read   <= go ? g_read : ~mon_read;
        mon_byte   <= ~go & ~mon_byte;
        // An opcode reaches execution one cycle after its fetch is seen.
        exec_valid <= mon_valid;
        exec_addr  <= mon_valid ? mon_addr : ~exec_addr;
    end
endmodule : dct_core_model

/* verif/dct_top_tb.sv */
`timescale 1ns/100ps
module dct_top_tb import dct_pkg::*;;
    logic                  clk = 1'b0, sys_rst = 1'b1, bus_req = 1'b0, bus_wr = 1'b0;
    logic                  bus_word = 1'b0, go = 1'b0, g_read = 1'b0, secured = 1'b0;
    logic                  bus_ack, mon_valid, mon_read, mon_byte, exec_valid, armed;
    logic                  breakpoint_req;
    logic [15:0]           bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, rd;
    logic [DCT_ADDR_W-1:0] mon_addr, exec_addr, aa, g_addr = '0;
    logic [DCT_DATA_W-1:0] mon_data, g_data = '0, ld[3];
    logic                  lr[3] = '{1'b1, 1'b0, 1'b0};
    int                    li[3] = '{0, 2, 3};
    int                    err_count = 0, compares = 0, cyc = 0, bp_cnt = 0;

    dct_top #(.TRACE_DEPTH(4)) dut_u (.clk, .sys_rst, .bus_req, .bus_wr, .bus_word, .bus_addr,
        .bus_wdata, .bus_rdata, .bus_ack, .mon_valid, .mon_addr, .mon_data, .mon_read,
        .mon_byte, .exec_valid, .exec_addr, .secured, .armed, .breakpoint_req);
    dct_core_model core_u (.clk, .go, .g_addr, .g_data, .g_read, .mon_valid, .mon_addr,
        .mon_data, .mon_read, .mon_byte, .exec_valid, .exec_addr);

    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        bp_cnt <= bp_cnt + int'(breakpoint_req === 1'b1);
        if (cyc == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic wd, input logic [15:0] a, input logic [15:0] w);
        @(posedge clk);
        {bus_req, bus_wr, bus_word, bus_addr, bus_wdata} <= {1'b1, wr, wd, a, w};
        @(posedge clk);
        bus_req <= 1'b0;
        #1 rd = bus_rdata;
        check("bus_ack", {15'h0000, bus_ack}, 16'h0001);
    endtask : bus
    function automatic logic [23:0] cadr(int v);
        return aa ^ {14'h0000, 2'(v), 8'h00};
    endfunction : cadr
    function automatic logic [15:0] exp_word(int w);
        int j = w / 4;
        case (w % 4)
            0: return {10'h000, lr[j], 3'h0, 2'(li[j])};
            1: return ld[j];
            2: return 16'(cadr(li[j]));
            default: return {8'h00, 8'(cadr(li[j]) >> 16)};
        endcase
    endfunction : exp_word
    task automatic drain(int n);
        for (int w = 0; w < n; w++) begin
            bus(0, 1, DCT_OFS_TBH, 0);
            check("trace word", rd, exp_word(w));
        end
    endtask : drain
    // Arms with no trace and expects a disarm exactly when a stop comparator matches.
    task automatic probe(input logic [23:0] a, input logic [15:0] d,
                         input logic r, input logic hit);
        bus(1, 0, DCT_OFS_CTRL, 16'h0080);
        @(posedge clk);
        {go, g_addr, g_data, g_read} <= {1'b1, a, d, r};
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        check("stop on match", {15'h0000, armed}, {15'h0000, !hit});
        bus(1, 0, DCT_OFS_CTRL, 16'h0000);
    endtask : probe
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hA10F751C));
        aa = {1'b1, 23'($urandom)};
        for (int j = 0; j < 3; j++) ld[j] = 16'($urandom);
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        // Comparators A to C match on address alone; only D ends the session.
        for (int v = 0; v < 4; v++) begin
            bus(1, 0, DCT_OFS_CTRL, 16'(v) | 16'h0040);
            bus(1, 0, DCT_OFS_WIN, (v == 3) ? 16'h0010 : 16'h0000);
            for (int b = 1; b < 4; b++) bus(1, 0, DCT_OFS_WIN + 16'(b), 8'(cadr(v) >> (24 - 8 * b)));
        end
        for (int v = 0; v < 4; v++) begin
            bus(1, 0, DCT_OFS_CTRL, 16'(v));
            bus(0, 0, DCT_OFS_WIN + 16'h0002, 0);
            check("window addr", rd, 8'(cadr(v) >> 8));
        end
        bus(0, 0, DCT_OFS_WIN, 0);
        check("view d ctl", rd, 16'h0010);
        $display("test window done");
        bus(1, 0, DCT_OFS_BRKEN, 1);
        bus(1, 0, DCT_OFS_CTRL, 16'h00C0);
        bus(0, 1, DCT_OFS_TBH, 0);
        check("armed read", rd, DCT_INVALID_WRD);
        for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            {go, g_addr, g_data, g_read} <= {1'b1, cadr(li[j]), ld[j], lr[j]};
            @(posedge clk);
            go <= 1'b0;
            repeat (4) @(posedge clk);
        end
        check("armed", {15'h0000, armed}, 16'h0000);
        check("breakpoints", 16'(bp_cnt), 16'h0001);
        $display("test capture done");
        bus(0, 1, DCT_OFS_TBH, 0);
        check("locked read", rd, 16'h0000);
        bus(1, 1, DCT_OFS_TBH, 0);
        bus(0, 0, DCT_OFS_TBL, 0);
        check("byte read", rd, 16'h0000);
        drain(12);
        bus(0, 0, DCT_OFS_CNT, 0);
        check("line count", rd, 16'h0003);
        bus(1, 1, DCT_OFS_TBH, 0);
        drain(1);
        secured <= 1'b1;
        bus(0, 1, DCT_OFS_TBH, 0);
        check("secured read", rd, 16'h0000);
        secured <= 1'b0;
        $display("test readout done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1, 0, DCT_OFS_CTRL, 16'h0040);
        bus(1, 1, DCT_OFS_TBH, 0);
        drain(4);
        bus(0, 0, DCT_OFS_CNT, 0);
        check("count after reset", rd, 16'h0003);
        $display("test reset done");
        // Stops on A to C, each behind a different set of qualifiers.
        bus(1, 1, DCT_OFS_WIN, {8'h50, aa[23:16]});
        bus(1, 1, DCT_OFS_WIN + 16'h0002, aa[15:0]);
        bus(1, 1, DCT_OFS_WIN + 16'h0004, ld[0]);
        bus(1, 1, DCT_OFS_WIN + 16'h0006, 16'hFF00);
        for (int v = 1; v < 3; v++) begin
            bus(1, 0, DCT_OFS_CTRL, 16'(v));
            bus(1, 1, DCT_OFS_WIN, {(v == 1) ? 8'hDC : 8'h34, aa[23:16]});
            bus(1, 1, DCT_OFS_WIN + 16'h0002, 16'(cadr(v)));
        end
        probe(cadr(0), ld[0] ^ (16'($urandom) & 16'h00FF), 1'b0, 1'b0);
        probe(cadr(0), ld[0] ^ 16'h0100, 1'b1, 1'b1);
        probe(cadr(1), ld[1], 1'b1, 1'b0);
        bus(1, 0, DCT_OFS_CTRL, 16'h0001);
        bus(1, 0, DCT_OFS_WIN, 16'h009C);
        probe(cadr(1), ld[1], 1'b0, 1'b0);
        probe(cadr(1), ld[1], 1'b1, 1'b1);
        probe(cadr(2), ld[2], 1'b1, 1'b1);
        $display("test qualifiers done");
        wrap_up();
    end
endmodule : dct_top_tb
